// ===== verilog/bma_map.svh
`ifndef BMA_MAP_SVH
`define BMA_MAP_SVH

// Register byte offsets on the APB slave.
`define BMA_CTRL_OFS 8'h00
`define BMA_STATUS_OFS 8'h04
`define BMA_LUT_INDEX_OFS 8'h08
`define BMA_LUT_DATA_OFS 8'h0c

// Control register field positions.
`define BMA_CTRL_FETCH_WAIT 0
`define BMA_CTRL_READY_DRIVE 1
`define BMA_CTRL_PRECHARGE 2
`define BMA_CTRL_DEFEAT 3
`define BMA_CTRL_A12_CMP 4
`define BMA_CTRL_CONSEC 5
`define BMA_CTRL_SIZE64K 6
`define BMA_CTRL_BANK_LSB 8
`define BMA_CTRL_BANK_MSB 11

// Control register reset value: all banks on, partial disable defeated.
`define BMA_CTRL_RESET 12'hf08

// Status register field positions.
`define BMA_STAT_WAIT_A 0
`define BMA_STAT_WAIT_B 1
`define BMA_STAT_PRE_1 2
`define BMA_STAT_PRE_2 3
`define BMA_STAT_BANK_LSB 4
`define BMA_STAT_BANK_MSB 7
`define BMA_STAT_LUT_EN 8

// Least precharge time at a 4 MHz processor clock, in nanoseconds.
`define BMA_PRECHARGE_MIN_NS 126

`endif

// ===== verilog/bma_pkg.sv
package bma_pkg;

   // Bus pins sampled from outside the pclk domain.
   typedef struct packed {
      logic board_selected;  // Board select, active high.
      logic word_request_n;  // Word transfer request, active low.
      logic pdbin;           // Read data strobe.
      logic pwr_n;           // Write strobe, active low.
      logic phantom_n;       // Phantom request, active low.
      logic sinta;           // Interrupt acknowledge status.
      logic bus_clock;       // Buffered bus clock.
      logic fetch_cycle_n;   // Opcode fetch status, active low.
      logic mem_request;     // Buffered memory request, active high.
      logic [23:0] addr;     // Address bus.
      logic [7:0] data_out;  // Data-out bus.
      logic [7:0] data_in;   // Data-in bus.
   } bma_bus_type;

   // Width of the sampled pin group.
   localparam int BMA_BUS_W = $bits(bma_bus_type);

endpackage : bma_pkg

// ===== verilog/bma_sync.sv
// Two-flop synchroniser for a group of pins.
module bma_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_q;  // First stage, read only by the second stage.
   logic [W-1:0] sync_q;  // Second stage, safe to use.

   // Both stages shift every clock.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end

   assign dout = sync_q;
endmodule : bma_sync

// ===== verilog/bma_access_ctrl.sv
// The APB register port and the register addresses are this design's own decisions.
`include "bma_map.svh"

module bma_access_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire bma_pkg::bma_bus_type bus_pins,
   output logic word_read_strobe,
   output logic byte_read_strobe,
   output logic word_write_strobe,
   output logic byte_write_strobe,
   output logic low_half_write_n,
   output logic high_half_write_n,
   output logic hi_out_buf_en,
   output logic hi_in_buf_en,
   output logic lo_in_buf_en,
   output logic [7:0] ram_lo_din,
   output logic [7:0] ram_hi_din,
   output logic [13:0] ram_addr,
   output logic [3:0] row_strobe_n,
   output logic bank_valid_n,
   output logic ready_out,
   output logic ready_oe
);
   import bma_pkg::*;

   bma_bus_type bus_s;            // Synchronised bus pins.
   logic [BMA_BUS_W-1:0] bus_raw; // Pins as a flat vector.

   // APB register state.
   logic [11:0] ctrl_q, ctrl_d;        // Configuration switches and jumpers.
   logic [7:0] lut_index_q, lut_index_d; // Table entry pointer.
   logic [31:0] prdata_q, prdata_d;    // Read data.
   logic pready_q, pready_d;           // Access phase ready.
   logic pslverr_q, pslverr_d;         // Unmapped address flag.
   logic [3:0] lut_mem [0:255];        // Bank select table.

   // Bus clock edge detect and sequential stages.
   logic clk_prev_q, clk_prev_d;       // Last bus clock level.
   logic wait_a_q, wait_a_d;           // Wait stage one, low on fetch.
   logic wait_b_q, wait_b_d;           // Wait stage two.
   logic pre1_q, pre1_d;               // Precharge stage one.
   logic pre2_q, pre2_d;               // Precharge stage two.
   logic bus_rise;                     // One-cycle enable on bus clock rise.

   // Registered outputs.
   logic [8:0] strobe_q, strobe_d;     // Strobes and buffer enables.
   logic [7:0] ram_lo_din_q, ram_lo_din_d;
   logic [7:0] ram_hi_din_q, ram_hi_din_d;
   logic [13:0] ram_addr_q, ram_addr_d;
   logic [3:0] row_strobe_n_q, row_strobe_n_d;
   logic bank_valid_n_q, bank_valid_n_d;
   logic ready_oe_q, ready_oe_d;

   // Decode terms.
   logic wreq, a0, defeat_eff, partial_ok, lut_en;
   logic [7:0] lut_addr;
   logic [3:0] lut_data, bank_sel_n, bank_enable;
   logic rd_base, wr_base, word_rd, byte_rd, word_wr, byte_wr, consec, precharge_block;
   logic apb_wr, apb_setup;

   // All bus pins cross into the pclk domain through two flops.
   assign bus_raw = bus_pins;
   bma_sync #(.W(BMA_BUS_W)) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .din(bus_raw),
      .dout(bus_s)
   );

   assign bank_enable = ctrl_q[`BMA_CTRL_BANK_MSB:`BMA_CTRL_BANK_LSB];
   assign consec = ctrl_q[`BMA_CTRL_CONSEC];
   assign bus_rise = bus_s.bus_clock & ~clk_prev_q;
   assign apb_setup = psel & ~penable;
   assign apb_wr = psel & penable & pready_q & pwrite;

   // Memory decode, combinational from the sampled bus.
   // decode stays combinational.
   always_comb begin
      wreq = ~bus_s.word_request_n;
      a0 = bus_s.addr[0];
      defeat_eff = ctrl_q[`BMA_CTRL_DEFEAT] | ~consec;
      partial_ok = defeat_eff | ~bus_s.addr[15] | ~bus_s.addr[14] | ~bus_s.addr[13]
                   | (ctrl_q[`BMA_CTRL_A12_CMP] & ~bus_s.addr[12]);
      lut_en = bus_s.board_selected & partial_ok;
      lut_addr = {wreq, bus_s.addr[17:14], a0, consec, ctrl_q[`BMA_CTRL_SIZE64K]};
      lut_data = lut_mem[lut_addr];
      bank_sel_n = lut_en ? (lut_data | ~bank_enable) : 4'hf;
      rd_base = bus_s.board_selected & bus_s.pdbin & ~(&bank_sel_n) & bus_s.phantom_n
                & ~bus_s.sinta;
      wr_base = bus_s.board_selected & ~bus_s.pwr_n;
      word_rd = rd_base & wreq;
      byte_rd = rd_base & ~wreq;
      word_wr = wr_base & wreq;
      byte_wr = wr_base & ~wreq;
   end

   // Output values: strobes, steering and row strobes.
   always_comb begin
      strobe_d[0] = word_rd;
      strobe_d[1] = byte_rd;
      strobe_d[2] = word_wr;
      strobe_d[3] = byte_wr;
      strobe_d[4] = ~(word_wr | (byte_wr & (a0 | consec)));
      strobe_d[5] = ~(word_wr | (byte_wr & (~a0 | consec)));
      strobe_d[6] = word_rd;
      strobe_d[7] = word_rd | (byte_rd & (~a0 | consec));
      strobe_d[8] = byte_rd & (a0 | consec);
      ram_lo_din_d = bus_s.data_out;
      ram_hi_din_d = wreq ? bus_s.data_in : bus_s.data_out;
      ram_addr_d = consec ? bus_s.addr[13:0] : bus_s.addr[14:1];
      bank_valid_n_d = &bank_sel_n;
      precharge_block = ctrl_q[`BMA_CTRL_PRECHARGE] & pre2_q;
      row_strobe_n_d = bank_sel_n | {4{~bus_s.mem_request | precharge_block}};
      ready_oe_d = ~wait_a_q & wait_b_q & bus_s.board_selected
                   & ctrl_q[`BMA_CTRL_READY_DRIVE];
   end

   // Wait and precharge stages, stepped on bus clock rises.
   always_comb begin
      clk_prev_d = bus_s.bus_clock;
      wait_a_d = wait_a_q;
      wait_b_d = wait_b_q;
      pre1_d = pre1_q;
      pre2_d = pre2_q;
      if (bus_rise) begin
         wait_a_d = bus_s.fetch_cycle_n | ~ctrl_q[`BMA_CTRL_FETCH_WAIT];
         wait_b_d = wait_a_q;
         pre1_d = ~bus_s.fetch_cycle_n;
         pre2_d = pre1_q;
      end
      if (!bus_s.mem_request) begin
         pre1_d = 1'b0;
         pre2_d = 1'b0;
      end
   end

   // APB slave: ready in the access phase, writes take effect there.
   always_comb begin
      ctrl_d = ctrl_q;
      lut_index_d = lut_index_q;
      prdata_d = prdata_q;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      if (apb_setup) begin
         // Answer is prepared in the setup cycle.
         pready_d = 1'b1;
         prdata_d = 32'h0000_0000;
         unique case (paddr)
            `BMA_CTRL_OFS: begin
               prdata_d[11:0] = ctrl_q;
            end
            `BMA_STATUS_OFS: begin
               prdata_d[`BMA_STAT_WAIT_A] = wait_a_q;
               prdata_d[`BMA_STAT_WAIT_B] = wait_b_q;
               prdata_d[`BMA_STAT_PRE_1] = pre1_q;
               prdata_d[`BMA_STAT_PRE_2] = pre2_q;
               prdata_d[`BMA_STAT_BANK_MSB:`BMA_STAT_BANK_LSB] = bank_sel_n;
               prdata_d[`BMA_STAT_LUT_EN] = lut_en;
            end
            `BMA_LUT_INDEX_OFS: begin
               prdata_d[7:0] = lut_index_q;
            end
            `BMA_LUT_DATA_OFS: begin
               prdata_d[3:0] = lut_mem[lut_index_q];
            end
            default: begin
               // Unmapped offsets read zero and flag an error.
               pslverr_d = 1'b1;
            end
         endcase
      end
      if (apb_wr) begin
         unique case (paddr)
            `BMA_CTRL_OFS: begin
               ctrl_d = pwdata[11:0];
            end
            `BMA_LUT_INDEX_OFS: begin
               lut_index_d = pwdata[7:0];
            end
            default: begin
               // Status and table data writes change no register here.
               ctrl_d = ctrl_q;
            end
         endcase
      end
   end

   // All control and output registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `BMA_CTRL_RESET;
         lut_index_q <= 8'h00;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         clk_prev_q <= 1'b0;
         wait_a_q <= 1'b1;
         wait_b_q <= 1'b1;
         pre1_q <= 1'b0;
         pre2_q <= 1'b0;
         strobe_q <= 9'h030;
         ram_lo_din_q <= 8'h00;
         ram_hi_din_q <= 8'h00;
         ram_addr_q <= 14'h0000;
         row_strobe_n_q <= 4'hf;
         bank_valid_n_q <= 1'b1;
         ready_oe_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         lut_index_q <= lut_index_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         clk_prev_q <= clk_prev_d;
         wait_a_q <= wait_a_d;
         wait_b_q <= wait_b_d;
         pre1_q <= pre1_d;
         pre2_q <= pre2_d;
         strobe_q <= strobe_d;
         ram_lo_din_q <= ram_lo_din_d;
         ram_hi_din_q <= ram_hi_din_d;
         ram_addr_q <= ram_addr_d;
         row_strobe_n_q <= row_strobe_n_d;
         bank_valid_n_q <= bank_valid_n_d;
         ready_oe_q <= ready_oe_d;
      end
   end

   // Table contents are data, loaded by software, not reset.
   always_ff @(posedge pclk) begin
      if (apb_wr && paddr == `BMA_LUT_DATA_OFS) begin
         lut_mem[lut_index_q] <= pwdata[3:0];
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign word_read_strobe = strobe_q[0];
   assign byte_read_strobe = strobe_q[1];
   assign word_write_strobe = strobe_q[2];
   assign byte_write_strobe = strobe_q[3];
   assign low_half_write_n = strobe_q[4];
   assign high_half_write_n = strobe_q[5];
   assign hi_out_buf_en = strobe_q[6];
   assign hi_in_buf_en = strobe_q[7];
   assign lo_in_buf_en = strobe_q[8];
   assign ram_lo_din = ram_lo_din_q;
   assign ram_hi_din = ram_hi_din_q;
   assign ram_addr = ram_addr_q;
   assign row_strobe_n = row_strobe_n_q;
   assign bank_valid_n = bank_valid_n_q;
   // Open-collector ready: the level is always low, the enable pulls.
   assign ready_out = 1'b0;
   assign ready_oe = ready_oe_q;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Word and byte reads never coincide.
   a_read_exclusive: assert property (!(word_read_strobe && byte_read_strobe))
      else $error("word and byte read strobes both high");

   // A word write strobes both halves the next cycle.
   a_word_write_both: assert property (word_wr |=> !low_half_write_n && !high_half_write_n)
      else $error("word write did not strobe both halves");

   // A byte write with bit zero high and consecutive mode off hits only the low half.
   a_byte_write_low: assert property (byte_wr && a0 && !consec
      |=> !low_half_write_n && high_half_write_n)
      else $error("byte write steered to wrong half");

   // A word read ignores bit zero and enables the high buffers only.
   a_word_read_bufs: assert property (word_rd && !consec
      |=> hi_out_buf_en && hi_in_buf_en && !lo_in_buf_en)
      else $error("word read buffer enables wrong");

   // Top 8K is refused when bit twelve is not compared.
   a_top8k_off: assert property (consec && !ctrl_q[`BMA_CTRL_DEFEAT]
      && !ctrl_q[`BMA_CTRL_A12_CMP] && bus_s.addr[15:13] == 3'h7 |=> bank_valid_n)
      else $error("top 8K still answered");

   // With bit twelve compared, E000 to EFFF stays enabled.
   a_top4k_only: assert property (consec && ctrl_q[`BMA_CTRL_A12_CMP]
      && bus_s.addr[15:12] == 4'he |-> lut_en == bus_s.board_selected)
      else $error("E000 page disabled in 4K mode");

   // Defeat keeps the table enabled with the board.
   a_defeat_enable: assert property (defeat_eff |-> lut_en == bus_s.board_selected)
      else $error("defeat did not hold table enabled");

   // A masked bank never gets a row strobe.
   a_bank_masked: assert property ((~$past(bank_enable) & ~row_strobe_n) == 4'h0)
      else $error("masked bank strobed");

   // A fetch stage fall starts a ready pull that lasts one bus clock period, eight pclk cycles.
   a_ready_start: assert property ($fell(wait_a_q) && wait_b_q && bus_s.board_selected
      && ctrl_q[`BMA_CTRL_READY_DRIVE] |=> ready_oe)
      else $error("ready not pulled after fetch");

   // The ready pull ends at the next bus clock rise and is not repeated.
   a_ready_single: assert property (ready_oe && bus_rise |-> ##2 !ready_oe)
      else $error("ready held low past the next bus clock rise");

   // Stages clear within a cycle of request going inactive.
   a_pre_reset: assert property (!bus_s.mem_request |=> !pre1_q && !pre2_q)
      else $error("precharge stages not reset");

   // A captured fetch blocks all row strobes.
   a_pre_block: assert property (ctrl_q[`BMA_CTRL_PRECHARGE] && pre2_q
      |=> row_strobe_n == 4'hf)
      else $error("row strobe while precharge stretch");

   c_word_read: cover property (word_read_strobe);
   c_byte_write: cover property (byte_write_strobe && !low_half_write_n);
   c_ready_pull: cover property (ready_oe);
   c_pre_block: cover property (pre2_q && ctrl_q[`BMA_CTRL_PRECHARGE]);
endmodule : bma_access_ctrl

// ===== tb/bma_bus_master_model.sv
// Behavioural bus master: a free bus clock, pins from the bench, opcode fetches.
module bma_bus_master_model
   import bma_pkg::*;
(
   input wire logic pclk,
   input wire bma_bus_type cmd,
   input wire logic ready_out,
   input wire logic ready_oe,
   output bma_bus_type pins
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] phase_q = 3'h0; // Divider, eight pclk cycles per bus clock.
   logic fetch_n = 1'b1; // Fetch status, idle high.
   wire logic bclk = phase_q[2]; // Bus clock made by the master.
   wire logic rdy = ready_oe ? ready_out : 1'b1; // Ready line with its pull-up.

   always @(posedge pclk) begin
      phase_q <= phase_q + 3'h1;
   end

   always_comb begin
      pins = cmd;
      pins.bus_clock = bclk;
      pins.fetch_cycle_n = fetch_n;
   end

   // one wait inserted.
   // Fetch status is low through T1 and released before T3; each fall of ready is a wait.
   task automatic fetch_cycle(output logic [7:0] n);
      logic prev;
      n = 8'h00;
      prev = 1'b1;
      @(posedge bclk);
      for (int i = 0; i < 56; i++) begin
         @(posedge pclk);
         fetch_n <= (i < 8) ? 1'b0 : 1'b1;
         @(negedge pclk);
         if (!rdy && prev) begin
            n = n + 8'h01;
         end
         prev = rdy;
      end
   endtask : fetch_cycle
endmodule : bma_bus_master_model

// ===== tb/bus_memory_access_control_tb_top.sv
// Self-checking bench for the access control block.
module bus_memory_access_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import bma_pkg::*;
   // One table row: pins in, strobes and row strobes expected.
   typedef struct packed {
      logic [5:0] ctl;
      logic [23:0] addr;
      logic [8:0] exp;
      logic [3:0] ras_n;
   } bma_row_type;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   // Idle pins: board off, no strobes, memory request on, fixed data bytes.
   bma_bus_type cmd = {6'b010110, 3'b011, 24'h0, 8'h5a, 8'ha5};
   bma_bus_type pins;
   logic [8:0] strobes; // Strobes, write lows and buffer enables in row order.
   logic [7:0] lo_din;
   logic [7:0] hi_din;
   logic [13:0] ram_addr;
   logic [3:0] ras_n;
   logic bank_valid_n;
   logic ready_out;
   logic ready_oe;
   logic [31:0] rdat;
   logic rerr;
   logic [7:0] nw;
   int k;
   int n_errors = 0;
   int checks_done = 0;
   // Rows: ctl is board, word_n, read, write_n, phantom_n, int ack.
   bma_row_type rows [13] = '{
      '{6'b101110, 24'h004002, 9'b100011110, 4'hd}, '{6'b101110, 24'h004003, 9'b100011110, 4'hd},
      '{6'b111110, 24'h008000, 9'b010011010, 4'hb}, '{6'b111110, 24'h00c001, 9'b010011001, 4'h7},
      '{6'b111100, 24'h000000, 9'b000011000, 4'he}, '{6'b111111, 24'h000000, 9'b000011000, 4'he},
      '{6'b111110, 24'h010000, 9'b000011000, 4'hf}, '{6'b011110, 24'h000000, 9'b000011000, 4'hf},
      '{6'b100010, 24'h000001, 9'b001000000, 4'he}, '{6'b110010, 24'h000001, 9'b000101000, 4'he},
      '{6'b110010, 24'h000000, 9'b000110000, 4'he}, '{6'b110010, 24'h010000, 9'b000110000, 4'hf},
      '{6'b010010, 24'h000000, 9'b000011000, 4'hf}};
   // Partial disable cases: control, address, row strobes.
   logic [31:0] pd [6] = '{32'hf20e000f, 32'hf20dfff7, 32'hf30e0007, 32'hf30f000f,
      32'hf28f0007, 32'hf00f0007};
   // Fetch wait cases: control, board select, wait count.
   logic [23:0] fw [4] = '{24'hf0b101, 24'hf0a100, 24'hf09100, 24'hf0b000};
   // Precharge cases: control, blocked cycle count.
   logic [23:0] pc [2] = '{24'hf0c008, 24'hf08000};

   always #25 pclk = ~pclk;

   bma_access_ctrl uut (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .bus_pins(pins),
      .word_read_strobe(strobes[8]),
      .byte_read_strobe(strobes[7]),
      .word_write_strobe(strobes[6]),
      .byte_write_strobe(strobes[5]),
      .low_half_write_n(strobes[4]),
      .high_half_write_n(strobes[3]),
      .hi_out_buf_en(strobes[2]),
      .hi_in_buf_en(strobes[1]),
      .lo_in_buf_en(strobes[0]),
      .ram_lo_din(lo_din),
      .ram_hi_din(hi_din),
      .ram_addr(ram_addr),
      .row_strobe_n(ras_n),
      .bank_valid_n(bank_valid_n),
      .ready_out(ready_out),
      .ready_oe(ready_oe)
   );

   bma_bus_master_model partner (
      .pclk(pclk),
      .cmd(cmd),
      .ready_out(ready_out),
      .ready_oe(ready_oe),
      .pins(pins)
   );

   // Compares a value and reports a mismatch at once.
   task automatic cmp_val(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : cmp_val

   // One APB transfer, held until pready is seen high at a rising edge.
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         n_errors++;
         $display("BAD %0t no ready from slave", $time);
      end
   endtask : apb

   // Sets the pins, then waits the three edges of pin latency.
   task automatic drive(input logic [5:0] ctl, input logic [23:0] a);
      bma_bus_type v;
      v = cmd;
      {v.board_selected, v.word_request_n, v.pdbin, v.pwr_n, v.phantom_n, v.sinta} = ctl;
      v.addr = a;
      @(posedge pclk);
      cmd <= v;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
   endtask : drive

   // Prints the verdict and ends the run.
   task automatic summarize();
      if (n_errors == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : summarize

   // Cuts a hang short.
   initial begin
      #(30000 * 50);
      n_errors++;
      summarize();
   end

   // Main sequence: reset, register access, table rows, then hand tests.
   initial begin
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      cmp_val(32'({strobes, ras_n, ready_oe}), 32'({9'b000011000, 4'hf, 1'b0}));
      @(posedge pclk);
      presetn <= 1'b1;
      apb(8'h00, 1'b0, 32'h0);
      cmp_val(rdat, 32'hf08);
      apb(8'h10, 1'b0, 32'h0);
      cmp_val({rdat[30:0], rerr}, 32'h1);
      // Idle status: wait stages high, no bank selected, table off.
      apb(8'h04, 1'b0, 32'h0);
      cmp_val(rdat, 32'hf3);
      for (int i = 0; i < 256; i++) begin
         apb(8'h08, 1'b1, 32'(i));
         apb(8'h0c, 1'b1, i[5] ? 32'hf : {28'h0, ~(4'h1 << i[4:3])});
      end
      apb(8'h08, 1'b1, 32'h18);
      apb(8'h0c, 1'b0, 32'h0);
      cmp_val(rdat, 32'h7);
      foreach (rows[i]) begin
         drive(rows[i].ctl, rows[i].addr);
         cmp_val(32'(strobes), 32'(rows[i].exp));
         cmp_val(32'(ras_n), 32'(rows[i].ras_n));
         cmp_val(32'(ram_addr), 32'(rows[i].addr[14:1]));
         cmp_val(32'({lo_din, hi_din}), {16'h0, 8'h5a, rows[i].ctl[4] ? 8'h5a : 8'ha5});
         cmp_val(32'(bank_valid_n), 32'(&rows[i].ras_n));
      end
      // A switched-off bank gives no row strobe; the others still do.
      apb(8'h00, 1'b1, 32'hd08);
      drive(6'b110110, 24'h004000);
      cmp_val(32'(ras_n), 32'hf);
      drive(6'b110110, 24'h008000);
      cmp_val(32'(ras_n), 32'hb);
      foreach (pd[i]) begin
         apb(8'h00, 1'b1, {20'h0, pd[i][31:20]});
         drive(6'b110110, {8'h0, pd[i][19:4]});
         cmp_val(32'(ras_n), 32'(pd[i][3:0]));
      end
      foreach (fw[i]) begin
         apb(8'h00, 1'b1, {20'h0, fw[i][23:12]});
         drive({fw[i][8], 5'b10110}, 24'h0);
         partner.fetch_cycle(nw);
         cmp_val(32'(nw), 32'(fw[i][7:0]));
      end
      foreach (pc[i]) begin
         apb(8'h00, 1'b1, {20'h0, pc[i][23:12]});
         drive(6'b110110, 24'h0);
         k = 0;
         fork
            partner.fetch_cycle(nw);
            repeat (64) begin
               @(negedge pclk);
               if (ras_n === 4'hf) begin
                  k++;
               end
            end
         join
         cmp_val(32'(k), 32'(pc[i][7:0]));
      end
      // Request inactive: the precharge stages stay clear through a fetch.
      @(posedge pclk);
      cmd.mem_request <= 1'b0;
      fork
         partner.fetch_cycle(nw);
         begin
            repeat (20) @(posedge pclk);
            apb(8'h04, 1'b0, 32'h0);
         end
      join
      cmp_val(32'(rdat[3:2]), 32'h0);
      cmp_val(32'(ras_n), 32'hf);
      summarize();
   end
endmodule : bus_memory_access_control_tb_top
